// ### verilog/clock_startup_pkg.sv
package clock_startup_pkg;

    // selected clock source family, decoded from the source select fuses
    typedef enum logic [2:0] {
        SRC_EXT_CLOCK,
        SRC_INT_RC,
        SRC_EXT_RC,
        SRC_LF_CRYSTAL,
        SRC_CRYSTAL
    } clk_src_e;

    // raw fuse codes; a fuse bit reads 1 when unprogrammed, 0 when programmed
    localparam logic [3:0] FUSE_EXT_CLOCK = 4'h0;
    localparam logic [3:0] FUSE_INT_RC_LO = 4'h1;
    localparam logic [3:0] FUSE_INT_RC_HI = 4'h4;
    localparam logic [3:0] FUSE_EXT_RC_LO = 4'h5;
    localparam logic [3:0] FUSE_EXT_RC_HI = 4'h8;
    localparam logic [3:0] FUSE_LF_CRYSTAL = 4'h9;
    localparam logic [3:0] FUSE_CRYSTAL_LO = 4'hA;

    // fuse state as shipped: internal rc, slowly rising power
    localparam logic [3:0] FACTORY_SOURCE_FUSES = 4'h1;
    localparam logic [1:0] FACTORY_STARTUP_FUSES = 2'h2;

    // start-up fuse codes
    localparam logic [1:0] SUT_00 = 2'h0;
    localparam logic [1:0] SUT_01 = 2'h1;
    localparam logic [1:0] SUT_10 = 2'h2;
    localparam logic [1:0] SUT_11 = 2'h3;

    // sleep mode codes presented by the sleep controller
    localparam logic [2:0] MODE_IDLE = 3'h0;
    localparam logic [2:0] MODE_ADC_QUIET = 3'h1;
    localparam logic [2:0] MODE_POWER_DOWN = 3'h2;
    localparam logic [2:0] MODE_POWER_SAVE = 3'h3;
    localparam logic [2:0] MODE_STANDBY = 3'h6;

    // delay counter width and the short counts
    localparam int CNT_W = 17;
    localparam logic [CNT_W-1:0] CNT_NONE = 17'h00000;
    localparam logic [CNT_W-1:0] WAKE_258_CYCLES = 17'h00102;
    localparam logic [CNT_W-1:0] WAKE_1K_CYCLES = 17'h00400;
    localparam logic [CNT_W-1:0] WAKE_OTHER_CYCLES = 17'h00006;
    localparam logic [CNT_W-1:0] RESET_SHORT_CYCLES = 17'h01000;

    // fuse synchroniser settle time after reset release
    localparam logic [1:0] SETTLE_LAST = 2'h3;

    // asynchronous timer frequency condition
    localparam longint MAIN_CLK_HZ = 40000000;
    localparam longint WATCH_XTAL_HZ = 32768;
    localparam longint ASY_MIN_RATIO = 4;
    localparam bit ASY_FREQ_OK = MAIN_CLK_HZ > ASY_MIN_RATIO * WATCH_XTAL_HZ;

endpackage

// ### verilog/delay_if.sv
`timescale 1ns/10ps
interface delay_if #(
    parameter int W = 17
);
    logic load;
    logic [W-1:0] length;
    logic tick;
    logic busy;
    logic done;

    modport ctrl (output load, output length, output tick,
                  input busy, input done);
    modport cnt (input load, input length, input tick,
                 output busy, output done);
endinterface

// ### verilog/startup_delay_counter.sv
`timescale 1ns/10ps
module startup_delay_counter (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // control side
    delay_if.cnt dly
);
    import clock_startup_pkg::*;

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic busy_q;
    logic busy_d;
    logic done_q;
    logic done_d;

    // load wins over a tick; a zero length finishes at once
    always_comb begin
        cnt_d = cnt_q;
        busy_d = busy_q;
        done_d = 1'b0;
        if (dly.load) begin
            cnt_d = dly.length;
            busy_d = (dly.length != CNT_NONE);
            done_d = (dly.length == CNT_NONE);
        end else if (busy_q && dly.tick) begin
            cnt_d = cnt_q - 17'h00001;
            if (cnt_q == 17'h00001) begin
                busy_d = 1'b0;
                done_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_q <= CNT_NONE;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            busy_q <= busy_d;
            done_q <= done_d;
        end
    end

    assign dly.busy = busy_q;
    assign dly.done = done_q; // one-cycle pulse after the last tick
endmodule

// ### verilog/clock_startup_ctrl.sv
`timescale 1ns/10ps
// What this block does
// (R1) core clock enable feeds register file, status and stack; off halts core
// (R2) each clock domain enable but program memory follows the sleep mode on its own
// (R3) peripheral clock serves timers, serial units, external interrupts
// (R4) async external interrupt detect on while asleep with peripheral clock halted
// (R5) two-wire address match runs async while asleep with peripheral clock halted
// (R6) program memory clock enable follows the core clock enable
// (R7) async timer clock from watch crystal, needs main clock above 4x crystal
// (R8) async timer allowed only when internal rc drives the main clock
// (R9) converter clock keeps running while core and peripheral clocks stop
// (R10) fuses 1111-1010 xtal, 1001 lf, 1000-0101 rc, 0100-0001 int, 0000 ext
// (R11) fuse bit 1 means unprogrammed, 0 means programmed
// (R12) wake from deep sleep counts source cycles before execution resumes
// (R13) after reset an extra delay counted on watchdog oscillator ticks
// (R14) reset delay is none, 4096 or 65536 watchdog cycles by start-up fuses
// (R15) fuses as shipped: source 0001, start-up 10
// (R16) crystal wake count 258, 1K or 16K by low source fuse and start-up
// (R17) low-frequency crystal wake count 1K or 32K; start-up code 11 reserved
// (R18) domain enables change only on clock edges, never glitch
// (R19) core clock off while any delay counts, on the cycle after it ends
module clock_startup_ctrl
    import clock_startup_pkg::*;
#(
    parameter logic [CNT_W-1:0] WAKE_16K_CYCLES = 17'h04000,
    parameter logic [CNT_W-1:0] WAKE_32K_CYCLES = 17'h08000,
    parameter logic [CNT_W-1:0] RESET_LONG_CYCLES = 17'h10000
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // fuses and watchdog oscillator (foreign domain)
    input wire logic [3:0] clock_source_select_fuses_in,
    input wire logic [1:0] startup_time_fuses_in,
    input wire logic watchdog_osc_in,
    // sleep controller
    input wire logic sleep_req_in,
    input wire logic [2:0] sleep_mode_in,
    input wire logic wake_in,
    // module requests
    input wire logic async_timer_req_in,
    input wire logic converter_req_in,
    // domain enables to the glitch-free clock gates
    output logic core_clock_en_out,
    output logic peripheral_clock_en_out,
    output logic program_memory_clock_en_out,
    output logic async_timer_clock_en_out,
    output logic converter_clock_en_out,
    // source and status
    output logic oscillator_en_out,
    output clock_startup_pkg::clk_src_e clock_source_out,
    output logic async_int_detect_en_out,
    output logic two_wire_addr_async_en_out,
    output logic startup_busy_out
);
    import clock_startup_pkg::*;

    typedef enum logic [2:0] {
        ST_FUSE_SETTLE,
        ST_RESET_DELAY,
        ST_RUN,
        ST_SLEEP,
        ST_WAKE_DELAY
    } ctrl_state_e;

    // fuse decode; raw bits compared as read, 1 = unprogrammed
    function automatic clk_src_e decode_source(input logic [3:0] f);
        clk_src_e s;
        if (f >= FUSE_CRYSTAL_LO) begin
            s = SRC_CRYSTAL; // R10 R11
        end else if (f == FUSE_LF_CRYSTAL) begin
            s = SRC_LF_CRYSTAL; // R10
        end else if (f >= FUSE_EXT_RC_LO && f <= FUSE_EXT_RC_HI) begin
            s = SRC_EXT_RC; // R10
        end else if (f >= FUSE_INT_RC_LO && f <= FUSE_INT_RC_HI) begin
            s = SRC_INT_RC; // R10
        end else begin
            s = SRC_EXT_CLOCK; // R10
        end
        return s;
    endfunction

    // wake-up count in cycles of the selected source
    function automatic logic [CNT_W-1:0] wake_cycles(
        input logic [3:0] f,
        input logic [1:0] sut
    );
        logic [CNT_W-1:0] n;
        n = WAKE_OTHER_CYCLES;
        case (decode_source(f))
            SRC_CRYSTAL: begin
                if (!f[0]) begin
                    n = sut[1] ? WAKE_1K_CYCLES : WAKE_258_CYCLES; // R16
                end else begin
                    n = (sut == SUT_00) ? WAKE_1K_CYCLES
                                        : WAKE_16K_CYCLES; // R16
                end
            end
            SRC_LF_CRYSTAL: begin
                // reserved code 11 handled as the long count
                n = sut[1] ? WAKE_32K_CYCLES : WAKE_1K_CYCLES; // R17
            end
            default: begin
                n = WAKE_OTHER_CYCLES;
            end
        endcase
        return n;
    endfunction

    // reset delay in watchdog oscillator cycles
    function automatic logic [CNT_W-1:0] reset_cycles(
        input logic [3:0] f,
        input logic [1:0] sut
    );
        logic [CNT_W-1:0] n;
        n = RESET_LONG_CYCLES;
        case (decode_source(f))
            SRC_CRYSTAL: begin
                case ({f[0], sut})
                    3'h0, 3'h3, 3'h6: n = RESET_SHORT_CYCLES; // R14
                    3'h2, 3'h5: n = CNT_NONE;
                    default: n = RESET_LONG_CYCLES; // R14
                endcase
            end
            SRC_LF_CRYSTAL: begin
                n = (sut == SUT_00) ? RESET_SHORT_CYCLES
                                    : RESET_LONG_CYCLES; // R14 R17
            end
            default: begin
                case (sut)
                    SUT_00: n = CNT_NONE;
                    SUT_01: n = RESET_SHORT_CYCLES; // R14
                    default: n = RESET_LONG_CYCLES; // R14
                endcase
            end
        endcase
        return n;
    endfunction

    // deep modes stop the oscillator and need a wake-up count
    function automatic logic is_deep(input logic [2:0] m);
        return (m == MODE_POWER_DOWN) || (m == MODE_POWER_SAVE);
    endfunction

    // synchronisers for the pins from outside the clock domain
    logic [3:0] src_s1_q;
    logic [3:0] src_s2_q;
    logic [1:0] sut_s1_q;
    logic [1:0] sut_s2_q;
    logic wdt_s1_q;
    logic wdt_s2_q;
    logic wdt_s3_q;
    logic wake_s1_q;
    logic wake_s2_q;
    logic wdt_tick;

    // fuse sync resets to factory state so an early read is sane
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            src_s1_q <= FACTORY_SOURCE_FUSES;
            src_s2_q <= FACTORY_SOURCE_FUSES;
            sut_s1_q <= FACTORY_STARTUP_FUSES;
            sut_s2_q <= FACTORY_STARTUP_FUSES;
            wdt_s1_q <= 1'b0;
            wdt_s2_q <= 1'b0;
            wdt_s3_q <= 1'b0;
            wake_s1_q <= 1'b0;
            wake_s2_q <= 1'b0;
        end else begin
            src_s1_q <= clock_source_select_fuses_in;
            src_s2_q <= src_s1_q;
            sut_s1_q <= startup_time_fuses_in;
            sut_s2_q <= sut_s1_q;
            wdt_s1_q <= watchdog_osc_in;
            wdt_s2_q <= wdt_s1_q;
            wdt_s3_q <= wdt_s2_q;
            wake_s1_q <= wake_in;
            wake_s2_q <= wake_s1_q;
        end
    end

    // one tick per watchdog oscillator rising edge
    assign wdt_tick = wdt_s2_q && !wdt_s3_q; // R13

    // shared delay counter for reset and wake-up counts
    delay_if #(.W(CNT_W)) dly ();

    startup_delay_counter u_delay (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .dly(dly)
    );

    // control state
    ctrl_state_e state_q;
    ctrl_state_e state_d;
    logic [1:0] settle_q;
    logic [1:0] settle_d;
    logic [3:0] src_fuse_q;
    logic [3:0] src_fuse_d;
    logic [1:0] sut_fuse_q;
    logic [1:0] sut_fuse_d;
    logic [2:0] mode_q;
    logic [2:0] mode_d;
    logic [CNT_W-1:0] reset_len;

    assign reset_len = reset_cycles(src_s2_q, sut_s2_q);

    // sequencing: settle fuses, reset delay, run, sleep, wake delay
    always_comb begin
        state_d = state_q;
        settle_d = settle_q;
        src_fuse_d = src_fuse_q;
        sut_fuse_d = sut_fuse_q;
        mode_d = mode_q;
        dly.load = 1'b0;
        dly.length = CNT_NONE;
        dly.tick = 1'b0;
        case (state_q)
            ST_FUSE_SETTLE: begin
                // fuses are caught only after the sync chain has filled
                settle_d = settle_q + 2'h1;
                if (settle_q == SETTLE_LAST) begin
                    src_fuse_d = src_s2_q;
                    sut_fuse_d = sut_s2_q;
                    dly.load = 1'b1;
                    dly.length = reset_len; // R13 R14
                    state_d = ST_RESET_DELAY;
                end
            end
            ST_RESET_DELAY: begin
                dly.tick = wdt_tick; // R13
                if (dly.done) begin
                    state_d = ST_RUN; // R19
                end
            end
            ST_RUN: begin
                if (sleep_req_in) begin
                    mode_d = sleep_mode_in; // R2
                    state_d = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (wake_s2_q) begin
                    if (is_deep(mode_q)) begin
                        dly.load = 1'b1;
                        dly.length = wake_cycles(src_fuse_q, sut_fuse_q);
                        state_d = ST_WAKE_DELAY; // R12
                    end else begin
                        state_d = ST_RUN;
                    end
                end
            end
            ST_WAKE_DELAY: begin
                // the clock here stands for the selected source
                dly.tick = 1'b1; // R12
                if (dly.done) begin
                    state_d = ST_RUN; // R12 R19
                end
            end
            default: begin
                state_d = ST_FUSE_SETTLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= ST_FUSE_SETTLE;
            settle_q <= 2'h0;
            src_fuse_q <= FACTORY_SOURCE_FUSES; // R15
            sut_fuse_q <= FACTORY_STARTUP_FUSES; // R15
            mode_q <= MODE_IDLE;
        end else begin
            state_q <= state_d;
            settle_q <= settle_d;
            src_fuse_q <= src_fuse_d;
            sut_fuse_q <= sut_fuse_d;
            mode_q <= mode_d;
        end
    end

    // domain enables, taken from the next state so they switch with it
    logic run_d;
    logic asleep_d;
    logic core_en_d;
    logic periph_en_d;
    logic asy_en_d;
    logic conv_en_d;
    logic osc_en_d;
    logic asy_src_ok;
    clk_src_e src_now;

    always_comb begin
        src_now = decode_source(src_fuse_d);
        run_d = (state_d == ST_RUN);
        asleep_d = (state_d == ST_SLEEP);
        core_en_d = run_d; // R1 R19
        periph_en_d = run_d || (asleep_d && mode_d == MODE_IDLE); // R2 R3
        // crystal pins are busy unless the internal rc is the source
        asy_src_ok = (src_now == SRC_INT_RC) && ASY_FREQ_OK; // R7 R8
        asy_en_d = async_timer_req_in && asy_src_ok
                   && (state_d != ST_FUSE_SETTLE)
                   && (state_d != ST_RESET_DELAY)
                   && (!(asleep_d || state_d == ST_WAKE_DELAY)
                       || mode_d != MODE_POWER_DOWN)
                   && (!asleep_d || mode_d != MODE_STANDBY); // R7
        conv_en_d = converter_req_in
                    && (run_d || (asleep_d && (mode_d == MODE_IDLE
                        || mode_d == MODE_ADC_QUIET))); // R9
        osc_en_d = !(asleep_d && is_deep(mode_d)); // R2
    end

    // registered enables: a gate cell latches them in the low phase
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            core_clock_en_out <= 1'b0;
            program_memory_clock_en_out <= 1'b0;
            peripheral_clock_en_out <= 1'b0;
            async_timer_clock_en_out <= 1'b0;
            converter_clock_en_out <= 1'b0;
            oscillator_en_out <= 1'b1;
            clock_source_out <= SRC_INT_RC;
            async_int_detect_en_out <= 1'b0;
            two_wire_addr_async_en_out <= 1'b0;
            startup_busy_out <= 1'b1;
        end else begin
            core_clock_en_out <= core_en_d; // R1 R18
            program_memory_clock_en_out <= core_en_d; // R6 R18
            peripheral_clock_en_out <= periph_en_d; // R3 R18
            async_timer_clock_en_out <= asy_en_d; // R7 R18
            converter_clock_en_out <= conv_en_d; // R9 R18
            oscillator_en_out <= osc_en_d;
            clock_source_out <= src_now; // R10
            async_int_detect_en_out <= asleep_d && !periph_en_d; // R4
            two_wire_addr_async_en_out <= asleep_d && !periph_en_d; // R5
            startup_busy_out <= !run_d && !asleep_d; // R19
        end
    end

endmodule

// ### verification/clock_startup_checker.sv
`timescale 1ns/10ps
module clock_startup_checker (
    // clock, reset, sleep controller and converter request
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic sleep_req_in,
    input wire logic [2:0] sleep_mode_in,
    input wire logic converter_req_in,
    // domain enables and status
    input wire logic core_clock_en_out,
    input wire logic peripheral_clock_en_out,
    input wire logic program_memory_clock_en_out,
    input wire logic async_timer_clock_en_out,
    input wire logic converter_clock_en_out,
    input wire logic oscillator_en_out,
    input wire clock_startup_pkg::clk_src_e clock_source_out,
    input wire logic async_int_detect_en_out,
    input wire logic two_wire_addr_async_en_out,
    input wire logic startup_busy_out
);
    import clock_startup_pkg::*;

    // one domain only, so clock and reset are given once
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    // sleep request taken while the core runs
    sequence s_taken(logic [2:0] m);
        core_clock_en_out && sleep_req_in && sleep_mode_in == m;
    endsequence

    a_flash_tracks_core: assert property (
        program_memory_clock_en_out == core_clock_en_out)
        else $error("program memory enable differs from core enable");
    a_core_held_busy: assert property (
        startup_busy_out |-> !core_clock_en_out)
        else $error("core enabled during start-up count");
    a_core_after_count: assert property (
        $fell(startup_busy_out) |-> core_clock_en_out)
        else $error("core not enabled when count ended");
    a_sleep_core_stop: assert property (
        core_clock_en_out && sleep_req_in |=> !core_clock_en_out)
        else $error("core kept running after sleep request");
    a_idle_keeps_io: assert property (
        s_taken(MODE_IDLE) |=> peripheral_clock_en_out && oscillator_en_out)
        else $error("idle sleep stopped peripheral clock");
    a_quiet_converter: assert property (
        s_taken(MODE_ADC_QUIET) ##0 converter_req_in
        |=> converter_clock_en_out && !peripheral_clock_en_out)
        else $error("converter clock wrong in quiet sleep");
    a_deep_osc_off: assert property (
        s_taken(MODE_POWER_DOWN) |=> !oscillator_en_out
        && !async_timer_clock_en_out && !converter_clock_en_out)
        else $error("power-down left a clock running");
    a_async_rc_only: assert property (
        async_timer_clock_en_out |-> clock_source_out == SRC_INT_RC)
        else $error("async timer clock without internal rc");
    a_detect_io_off: assert property (
        async_int_detect_en_out |-> !peripheral_clock_en_out)
        else $error("async detect on while peripheral clock runs");
    a_addr_io_off: assert property (
        two_wire_addr_async_en_out |-> !peripheral_clock_en_out
        && !core_clock_en_out)
        else $error("async address match on with clocks running");
    a_wake_min_count: assert property (
        $rose(oscillator_en_out) |-> !core_clock_en_out [*6])
        else $error("core woke before oscillator count");
    a_source_fixed: assert property (
        !startup_busy_out |=> $stable(clock_source_out))
        else $error("clock source changed after start-up");
endmodule

bind clock_startup_ctrl clock_startup_checker u_clock_startup_checker (
    .clk_in, .rst_n_in, .sleep_req_in, .sleep_mode_in, .converter_req_in,
    .core_clock_en_out, .peripheral_clock_en_out,
    .program_memory_clock_en_out, .async_timer_clock_en_out,
    .converter_clock_en_out, .oscillator_en_out, .clock_source_out,
    .async_int_detect_en_out, .two_wire_addr_async_en_out,
    .startup_busy_out
);

// ### verification/watchdog_osc_model.sv
`timescale 1ns/10ps
module watchdog_osc_model #(
    parameter int HALF_NS = 55
) (
    // control from the bench
    input wire logic run_in,
    input wire logic clear_in,
    // oscillator and tick count
    output logic watchdog_osc_out,
    output logic [15:0] tick_count_out
);
    // unrelated to clk_in; parks low when stopped so no edge leaks
    initial begin
        watchdog_osc_out = 1'b0;
        forever begin
            #(HALF_NS);
            watchdog_osc_out = run_in ? ~watchdog_osc_out : 1'b0;
        end
    end

    // rising edges counted so the reset delay can be judged
    always @(posedge watchdog_osc_out or posedge clear_in) begin
        if (clear_in) begin
            tick_count_out <= 16'h0000;
        end else begin
            tick_count_out <= tick_count_out + 16'h0001;
        end
    end
endmodule

// ### verification/clock_source_and_startup_control_bench.sv
`timescale 1ns/10ps
module clock_source_and_startup_control_bench;
    import clock_startup_pkg::*;
    localparam int RESET_LONG = 64;
    localparam logic [2:0] MODES [5] = '{MODE_IDLE, MODE_ADC_QUIET,
        MODE_POWER_DOWN, MODE_POWER_SAVE, MODE_STANDBY};
    localparam logic [7:0] MODE_VEC [5] = '{8'h3C, 8'h1F, 8'h03, 8'h0B, 8'h07};
    logic clk_in = 1'b0;
    logic rst_n_in, sleep_req, wake, async_req, conv_req, wdt_osc;
    logic wdt_run, wdt_clr, core_en, periph_en, prog_en, async_en;
    logic conv_en, osc_en, det_en, tw_en, busy;
    logic [3:0] src_fuses;
    logic [1:0] sut_fuses;
    logic [2:0] sleep_mode;
    logic [15:0] ticks;
    logic [7:0] en_vec;
    clk_src_e clk_src;
    int err_count = 0;
    int num_checks = 0;

    // enables gathered so one compare covers a whole mode
    assign en_vec = {core_en, prog_en, periph_en, conv_en, async_en, osc_en,
        det_en, tw_en};
    always #12.5 clk_in = ~clk_in;

    // long counts shortened so the run stays short
    clock_startup_ctrl #(.WAKE_16K_CYCLES(17'h00010),
        .WAKE_32K_CYCLES(17'h00020), .RESET_LONG_CYCLES(17'h00040))
    u_clock_startup_ctrl (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .clock_source_select_fuses_in(src_fuses),
        .startup_time_fuses_in(sut_fuses), .watchdog_osc_in(wdt_osc),
        .sleep_req_in(sleep_req), .sleep_mode_in(sleep_mode),
        .wake_in(wake), .async_timer_req_in(async_req),
        .converter_req_in(conv_req), .core_clock_en_out(core_en),
        .peripheral_clock_en_out(periph_en),
        .program_memory_clock_en_out(prog_en),
        .async_timer_clock_en_out(async_en),
        .converter_clock_en_out(conv_en), .oscillator_en_out(osc_en),
        .clock_source_out(clk_src), .async_int_detect_en_out(det_en),
        .two_wire_addr_async_en_out(tw_en), .startup_busy_out(busy));
    watchdog_osc_model u_watchdog_osc_model (.run_in(wdt_run),
        .clear_in(wdt_clr), .watchdog_osc_out(wdt_osc),
        .tick_count_out(ticks));

    task automatic wrap_up();
        if (err_count == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check_bits(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
        end
    endtask

    task automatic check_range(input int got, input int lo, input int hi);
        num_checks++;
        if (got < lo || got > hi) begin
            err_count++;
            $display("unexpected at %0t: got %0h want %0h", $time, got, lo);
        end
    endtask

    // reset with given fuses; outputs judged while reset is held
    task automatic do_reset(input logic [3:0] src, input logic [1:0] sut,
            input logic run);
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        src_fuses <= src;
        sut_fuses <= sut;
        wdt_run <= run;
        wdt_clr <= 1'b1;
        repeat (4) @(posedge clk_in);
        #1 check_bits(en_vec, 8'h04);
        check_bits({4'h0, busy, clk_src}, {4'h0, 1'b1, SRC_INT_RC});
        @(posedge clk_in);
        rst_n_in <= 1'b1;
        wdt_clr <= 1'b0;
    endtask

    task automatic wait_ready();
        int n;
        n = 0;
        while (busy !== 1'b0) begin
            @(posedge clk_in);
            #1;
            n++;
            if (n > 40000) begin
                err_count++;
                wrap_up();
            end
        end
    endtask

    task automatic enter_sleep(input logic [2:0] mode);
        @(posedge clk_in);
        sleep_mode <= mode;
        sleep_req <= 1'b1;
        @(posedge clk_in);
        sleep_req <= 1'b0;
        #1;
    endtask

    // edges from raising wake until the core runs again
    task automatic wake_count(output int n);
        @(posedge clk_in);
        wake <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_in);
            #1;
            n++;
            if (n > 3000) begin
                err_count++;
                wrap_up();
            end
        end while (core_en !== 1'b1);
        repeat (2) @(posedge clk_in);
        wake <= 1'b0;
    endtask

    // watchdog held still first: the delay must not end on its own
    task automatic t_reset_delay(input logic [3:0] src, input logic [1:0] sut,
            input int exp);
        do_reset(src, sut, 1'b0);
        repeat (40) @(posedge clk_in);
        #1 check_bits({7'h00, busy}, {7'h00, exp != 0});
        @(posedge clk_in);
        wdt_run <= 1'b1;
        wait_ready();
        check_range(int'(ticks), exp, exp + 1);
        check_bits(en_vec, 8'hFC);
        check_bits({5'h00, clk_src}, {5'h00, SRC_INT_RC});
    endtask

    task automatic t_decode();
        clk_src_e exp;
        for (int f = 0; f < 16; f++) begin
            exp = f == 0 ? SRC_EXT_CLOCK : f < 5 ? SRC_INT_RC :
                f < 9 ? SRC_EXT_RC : f == 9 ? SRC_LF_CRYSTAL : SRC_CRYSTAL;
            do_reset(4'(f), SUT_00, 1'b0);
            repeat (8) @(posedge clk_in);
            #1 check_bits({5'h00, clk_src}, {5'h00, exp});
        end
    endtask

    // power-down wake counted in cycles of the selected source
    task automatic t_wake(input logic [3:0] src, input logic [1:0] sut,
            input int n_exp);
        int n;
        do_reset(src, sut, 1'b1);
        wait_ready();
        check_bits(en_vec, (src inside {[1:4]}) ? 8'hFC : 8'hF4);
        enter_sleep(MODE_POWER_DOWN);
        wake_count(n);
        check_range(n, n_exp + 3, n_exp + 5);
    endtask

    task automatic t_modes();
        int n;
        logic deep;
        do_reset(4'h1, SUT_00, 1'b1);
        wait_ready();
        for (int i = 0; i < 5; i++) begin
            deep = MODES[i] inside {MODE_POWER_DOWN, MODE_POWER_SAVE};
            enter_sleep(MODES[i]);
            check_bits(en_vec, MODE_VEC[i]);
            wake_count(n);
            check_range(n, deep ? 9 : 1, deep ? 11 : 3);
            check_bits(en_vec, 8'hFC);
        end
    endtask

    // main sequence; requests stay high to expose every gate
    initial begin
        rst_n_in = 1'b0;
        src_fuses = FACTORY_SOURCE_FUSES;
        sut_fuses = FACTORY_STARTUP_FUSES;
        sleep_req = 1'b0;
        sleep_mode = MODE_IDLE;
        wake = 1'b0;
        async_req = 1'b1;
        conv_req = 1'b1;
        wdt_run = 1'b0;
        // low at start so the first reset gives the tick counter a clear edge
        wdt_clr = 1'b0;
        t_reset_delay(FACTORY_SOURCE_FUSES, FACTORY_STARTUP_FUSES,
            RESET_LONG);
        t_reset_delay(4'h2, SUT_01, 4096);
        t_reset_delay(4'h3, SUT_00, 0);
        t_decode();
        t_wake(4'hE, SUT_01, 258);
        t_wake(4'hE, SUT_10, 1024);
        t_wake(4'hF, SUT_01, 16);
        t_wake(4'h9, SUT_10, 32);
        t_wake(4'h9, SUT_11, 32);
        t_wake(4'h6, SUT_00, 6);
        t_modes();
        wrap_up();
    end
endmodule
